// ---- design/bitr_pkg.sv ----
package bitr_pkg;

	// processor clock
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned CPU_CLK_HZ     = 2_000_000;
	localparam int unsigned CPU_DIV        = CLK_HZ / CPU_CLK_HZ;
	localparam int unsigned CNT_W          = 16;
	localparam int unsigned NUM_CH         = 3;

	// register map (word addresses on the plain port)
	localparam logic [3:0] ADDR_SEL        = 4'h0;
	localparam logic [3:0] ADDR_RELOAD0    = 4'h1;
	localparam logic [3:0] ADDR_RELOAD1    = 4'h2;
	localparam logic [3:0] ADDR_RELOAD2    = 4'h3;
	localparam logic [3:0] ADDR_COUNT0     = 4'h4;
	localparam logic [3:0] ADDR_COUNT1     = 4'h5;
	localparam logic [3:0] ADDR_COUNT2     = 4'h6;
	localparam logic [3:0] ADDR_STATUS     = 4'h7;
	localparam logic [3:0] ADDR_PEND       = 4'h8;

	// selector slot codes
	typedef enum logic [2:0] {
		BITR_SRC_GND = 3'h0,
		BITR_SRC_RX  = 3'h1,
		BITR_SRC_TX  = 3'h2,
		BITR_SRC_PC0 = 3'h3,
		BITR_SRC_PC3 = 3'h4
	} bitr_src_t;

	// field positions in the selector register
	localparam int unsigned SEL_A_LSB      = 0;
	localparam int unsigned SEL_B_LSB      = 4;
	localparam logic [7:0]  SEL_RESET      = 8'h00;
	localparam logic [15:0] RELOAD_RESET   = 16'hffff;

	// status bit positions
	localparam int unsigned ST_OUT0        = 0;
	localparam int unsigned ST_OUT1        = 1;
	localparam int unsigned ST_OUT2        = 2;
	localparam int unsigned ST_EDGE_PEND   = 3;
	localparam int unsigned ST_MID         = 4;

endpackage

// ---- design/bitr_top.sv ----
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// - one edge request per rising transition
// - mid restart request follows input level
// - mid restart is OR of two slots
// - both slots default to ground
// - low restart, vectored, trap held low
// - channel 0 output drives edge input
// - channel 1 from cpu clock, baud out
// - channel 2 from cpu clock, connector pin
// - channels decrement on falling clock edges
// - counts readable anytime without disturbing them
// - channel 0 from cpu clock, gate true
module bitr_top
	import bitr_pkg::*;
#(
	parameter int unsigned CW = bitr_pkg::CNT_W
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// register port
	input  wire logic [3:0]    addr,
	input  wire logic [15:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic [15:0]        rdata,
	// peripheral request pins
	input  wire logic          serial_receive_ready,
	input  wire logic          serial_transmit_ready,
	input  wire logic          parallel_port_c_bit0,
	input  wire logic          parallel_port_c_bit3,
	// processor side
	input  wire logic          edge_irq_taken,
	output logic               edge_restart_irq,
	output logic               mid_level_restart_irq,
	output logic               low_level_restart_irq,
	output logic               vectored_irq_request,
	output logic               trap_irq,
	// counter outputs
	output logic               baud_clock,
	output logic               connector_timer_out
);
	import bitr_pkg::*;

	typedef struct packed {
		logic [7:0]  sel;
		logic [2:0]  div;
		logic        cpu_clk;
		logic        edge_prev;
		logic        edge_pend;
		logic        mid;
		logic        low;
		logic        vec;
		logic        trap;
		logic        baud;
		logic        conn;
		logic [15:0] rdata;
	} bitr_state_t;

	bitr_state_t               s_q;
	bitr_state_t               s_d;
	logic [3:0]                pins;
	logic [3:0]                pins_s;
	logic                      cpu_fall;
	logic                      wr_sel;
	logic [NUM_CH-1:0]         wr_rld;
	logic [NUM_CH-1:0][CW-1:0] reload;
	logic [NUM_CH-1:0][CW-1:0] count;
	logic [NUM_CH-1:0]         cout;

	// slot code to request level; spare codes read as ground
	function automatic logic pick(input logic [2:0] code, input logic [3:0] src);
		logic r;
		r = 1'b0;
		case (code)
			BITR_SRC_RX:  r = src[0];
			BITR_SRC_TX:  r = src[1];
			BITR_SRC_PC0: r = src[2];
			BITR_SRC_PC3: r = src[3];
			default:      r = 1'b0;
		endcase
		return r;
	endfunction

	assign pins = {parallel_port_c_bit3, parallel_port_c_bit0,
		serial_transmit_ready, serial_receive_ready};

	// request pins cross two flops before any logic sees them
	bitr_sync #(
		.W    (4)
	) bitr_sync_inst (
		.clk  (clk),
		.rstn (rstn),
		.d    (pins),
		.q    (pins_s)
	);

	// channel 0: output feeds the edge input
	bitr_chan #(
		.CW       (CW)
	) bitr_chan_inst0 (
		.clk      (clk),
		.rstn     (rstn),
		.tick     (cpu_fall),
		.load     (wr_rld[0]),
		.load_val (CW'(wdata)),
		.reload   (reload[0]),
		.count    (count[0]),
		.wave     (cout[0])
	);

	// channel 1: output is the serial bit clock
	bitr_chan #(
		.CW       (CW)
	) bitr_chan_inst1 (
		.clk      (clk),
		.rstn     (rstn),
		.tick     (cpu_fall),
		.load     (wr_rld[1]),
		.load_val (CW'(wdata)),
		.reload   (reload[1]),
		.count    (count[1]),
		.wave     (cout[1])
	);

	// channel 2: output goes to the connector pin
	bitr_chan #(
		.CW       (CW)
	) bitr_chan_inst2 (
		.clk      (clk),
		.rstn     (rstn),
		.tick     (cpu_fall),
		.load     (wr_rld[2]),
		.load_val (CW'(wdata)),
		.reload   (reload[2]),
		.count    (count[2]),
		.wave     (cout[2])
	);

	always_comb begin
		s_d      = s_q;
		cpu_fall = 1'b0;
		wr_sel   = 1'b0;
		wr_rld   = '0;

		// write decode; unmapped addresses are ignored
		if (wr) begin
			if (addr == ADDR_SEL) begin
				wr_sel = 1'b1;
			end else if (addr == ADDR_RELOAD0) begin
				wr_rld[0] = 1'b1;
			end else if (addr == ADDR_RELOAD1) begin
				wr_rld[1] = 1'b1;
			end else if (addr == ADDR_RELOAD2) begin
				wr_rld[2] = 1'b1;
			end
		end

		// processor clock made by dividing the fast clock
		if (s_q.div == 3'(CPU_DIV - 1)) begin
			s_d.div = 3'h0;
		end else begin
			s_d.div = s_q.div + 3'h1;
		end
		if (s_q.div == 3'h0) begin
			s_d.cpu_clk = 1'b1;
		end else if (s_q.div == 3'(CPU_DIV / 2)) begin
			s_d.cpu_clk = 1'b0;
			cpu_fall    = s_q.cpu_clk;
		end

		// sampled low-then-high pair sets pending; set beats clear
		s_d.edge_prev = cout[0];
		if (cout[0] && !s_q.edge_prev) begin
			s_d.edge_pend = 1'b1;
		end else if (edge_irq_taken) begin
			s_d.edge_pend = 1'b0;
		end

		// mid request follows synced levels with no latch, so a flag
		// that software clears withdraws the request by itself
		s_d.mid = pick(s_q.sel[SEL_A_LSB +: 3], pins_s)
			| pick(s_q.sel[SEL_B_LSB +: 3], pins_s);
		if (wr_sel) begin
			s_d.sel = wdata[7:0];
		end

		// nothing on this board drives these, so they stay inactive
		s_d.low  = 1'b0;
		s_d.vec  = 1'b0;
		s_d.trap = 1'b0;

		s_d.baud = cout[1];
		s_d.conn = cout[2];

		// reads never touch count state; read data stands one cycle
		s_d.rdata = 16'h0000;
		if (rd) begin
			if (addr == ADDR_SEL) begin
				s_d.rdata = {8'h00, s_q.sel};
			end else if (addr == ADDR_RELOAD0) begin
				s_d.rdata = 16'(reload[0]);
			end else if (addr == ADDR_RELOAD1) begin
				s_d.rdata = 16'(reload[1]);
			end else if (addr == ADDR_RELOAD2) begin
				s_d.rdata = 16'(reload[2]);
			end else if (addr == ADDR_COUNT0) begin
				s_d.rdata = 16'(count[0]);
			end else if (addr == ADDR_COUNT1) begin
				s_d.rdata = 16'(count[1]);
			end else if (addr == ADDR_COUNT2) begin
				s_d.rdata = 16'(count[2]);
			end else if (addr == ADDR_STATUS) begin
				s_d.rdata = {11'h000, s_q.mid, s_q.edge_pend, cout};
			end else if (addr == ADDR_PEND) begin
				s_d.rdata = {15'h0000, s_q.edge_pend};
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q     <= '0;
			s_q.sel <= SEL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata                 = s_q.rdata;
	assign edge_restart_irq      = s_q.edge_pend;
	assign mid_level_restart_irq = s_q.mid;
	assign low_level_restart_irq = s_q.low;
	assign vectored_irq_request  = s_q.vec;
	assign trap_irq              = s_q.trap;
	assign baud_clock            = s_q.baud;
	assign connector_timer_out   = s_q.conn;

endmodule

module bitr_chan
	import bitr_pkg::*;
#(
	parameter int unsigned CW = bitr_pkg::CNT_W
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// channel clock and reload write
	input  wire logic          tick,
	input  wire logic          load,
	input  wire logic [CW-1:0] load_val,
	// state seen by the register port
	output logic [CW-1:0]      reload,
	output logic [CW-1:0]      count,
	output logic               wave
);
	import bitr_pkg::*;

	typedef struct packed {
		logic [CW-1:0] reload;
		logic [CW-1:0] count;
		logic          wave;
	} bitr_chan_t;

	bitr_chan_t c_q;
	bitr_chan_t c_d;

	// one falling edge of the channel clock: count down, reload at the end
	function automatic logic [CW-1:0] step(input logic [CW-1:0] c, input logic [CW-1:0] r);
		logic [CW-1:0] n;
		if (c <= CW'(1)) begin
			n = r;
		end else begin
			n = c - CW'(1);
		end
		return n;
	endfunction

	// square wave: high while the count is in its upper half
	function automatic logic half(input logic [CW-1:0] c, input logic [CW-1:0] r);
		return c > (r >> 1);
	endfunction

	always_comb begin
		c_d = c_q;
		if (load) begin
			// a new reload restarts the count at once, no stale long period
			c_d.reload = load_val;
			c_d.count  = load_val;
		end else if (tick) begin
			c_d.count = step(c_q.count, c_q.reload);
			c_d.wave  = half(c_d.count, c_q.reload);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			c_q        <= '0;
			c_q.reload <= CW'(RELOAD_RESET);
			c_q.count  <= CW'(RELOAD_RESET);
		end else begin
			c_q <= c_d;
		end
	end

	assign reload = c_q.reload;
	assign count  = c_q.count;
	assign wave   = c_q.wave;

endmodule

module bitr_sync #(
	parameter int unsigned W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// levels from outside the clock domain
	input  wire logic [W-1:0] d,
	// levels after two flops
	output logic [W-1:0]      q
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} bitr_sync_t;

	bitr_sync_t f_q;
	bitr_sync_t f_d;

	// only the second flop is read, the first may still be settling
	always_comb begin
		f_d        = f_q;
		f_d.first  = d;
		f_d.second = f_q.first;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

	assign q = f_q.second;

endmodule

// ---- tb/bitr_chk.sv ----
`timescale 1ns/1ps
module bitr_chk (
	input wire logic        clk, rstn, wr, rd, edge_irq_taken,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata, rdata,
	input wire logic        serial_receive_ready, serial_transmit_ready,
	input wire logic        parallel_port_c_bit0, parallel_port_c_bit3,
	input wire logic        edge_restart_irq, mid_level_restart_irq,
	input wire logic        low_level_restart_irq, vectored_irq_request, trap_irq
);
	import bitr_pkg::*;
	logic [7:0] sel_q, src;
	logic [2:0] age_q;
	logic       hit;
	assign src = {3'h0, parallel_port_c_bit3, parallel_port_c_bit0,
		serial_transmit_ready, serial_receive_ready, 1'b0};
	assign hit = src[sel_q[2:0]] | src[sel_q[6:4]];
	// age masks the cycles where a new selection is still settling
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_q <= 8'h00;
			age_q <= 3'h0;
		end else if (wr && addr == ADDR_SEL) begin
			sel_q <= wdata[7:0];
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_low_tied: assert property (!low_level_restart_irq)
		else $error("low restart raised");
	a_vec_tied: assert property (!vectored_irq_request)
		else $error("vectored request raised");
	a_trap_tied: assert property (!trap_irq)
		else $error("trap raised");
	a_edge_held: assert property (edge_restart_irq && !edge_irq_taken |=> edge_restart_irq)
		else $error("edge request dropped");
	a_mid_or_level: assert property (age_q > 3'h4 |-> mid_level_restart_irq == $past(hit, 3))
		else $error("mid request wrong");
	a_pend_read: assert property (rd && addr == ADDR_PEND |=> rdata[0] == $past(edge_restart_irq))
		else $error("pending bit read wrong");
	a_unmapped_zero: assert property (rd && addr > ADDR_PEND |=> rdata == 16'h0000)
		else $error("unmapped read nonzero");
	a_idle_rdata: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data without read");
endmodule
bind bitr_top bitr_chk bitr_chk_inst (.*);

// ---- tb/bitr_peer.sv ----
`timescale 1ns/1ps
module bitr_peer (
	input wire logic       clk, rstn, edge_restart_irq, slow,
	input wire logic [3:0] lines_set,
	output logic [3:0]     lines,
	output logic           edge_irq_taken,
	output logic [7:0]     taken_n
);
	logic [2:0] wait_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lines <= 4'h0;
			edge_irq_taken <= 1'b0;
			taken_n <= 8'h00;
			wait_q <= 3'h0;
		end else begin
			// flags stay up until software withdraws them
			lines <= lines_set;
			edge_irq_taken <= 1'b0;
			if (edge_restart_irq && !edge_irq_taken) begin
				wait_q <= wait_q + 3'h1;
				if (!slow || wait_q == 3'h7) begin
					edge_irq_taken <= 1'b1;
					taken_n <= taken_n + 8'h01;
					wait_q <= 3'h0;
				end
			end
		end
	end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import bitr_pkg::*;
	logic        clk = 0, rstn = 0, wr = 0, rd = 0, rd_q = 0, slow = 0;
	logic        taken, irq, mid, baud, conn;
	logic [1:0]  last_q = 2'h0;
	logic [3:0]  addr = 4'h0, lines_set = 4'h0, lines;
	logic [7:0]  taken_n, n0;
	logic [15:0] wdata = 16'h0, rdata, expq[$];
	int          fail_count = 0, compares = 0, cyc = 0, nb = 0, nc = 0;
	logic [2:0]  b;
	initial forever #50 clk = ~clk;
	bitr_top bitr_top_inst (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
		.serial_receive_ready(lines[0]), .serial_transmit_ready(lines[1]),
		.parallel_port_c_bit0(lines[2]), .parallel_port_c_bit3(lines[3]),
		.edge_irq_taken(taken), .edge_restart_irq(irq), .mid_level_restart_irq(mid),
		.low_level_restart_irq(), .vectored_irq_request(), .trap_irq(),
		.baud_clock(baud), .connector_timer_out(conn));
	bitr_peer bitr_peer_inst (.clk, .rstn, .edge_restart_irq(irq), .slow, .lines_set,
		.lines, .edge_irq_taken(taken), .taken_n);
	task automatic check(input string nm, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a; rd <= 1'b1; expq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	function automatic logic pick(input logic [2:0] c, input logic [3:0] l);
		return (c >= 3'h1 && c <= 3'h4) ? l[c - 3'h1] : 1'b0;
	endfunction
	always @(posedge clk) begin
		rd_q <= rd;
		last_q <= {baud, conn};
		if (baud && !last_q[1]) nb++;
		if (conn && !last_q[0]) nc++;
		if (rd_q) check("rdata", rdata, expq.pop_front());
		if (++cyc > 6000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		void'($urandom(32'hfa72c84d));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 16; a++)
			if (a < 4 || a > 8) rreg(4'(a), (a > 0 && a < 4) ? RELOAD_RESET : 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			b = 3'($urandom);
			wreg(ADDR_SEL, {9'h0, b, 1'b0, 3'(i)});
			lines_set <= i[3] ? 4'hf : 4'($urandom);
			repeat (6) @(posedge clk);
			check("mid", mid, pick(3'(i), lines_set) | pick(b, lines_set));
		end
		$display("test selector done");
		wreg(ADDR_RELOAD0, 16'd10);
		for (int j = 0; j < 2; j++) begin
			slow <= j[0];
			repeat (100) @(posedge clk);
			n0 = taken_n;
			repeat (500) @(posedge clk);
			check("edge count", (taken_n - n0) inside {[9:11]}, 1);
		end
		$display("test edge done");
		wreg(ADDR_RELOAD1, 16'd4);
		wreg(ADDR_RELOAD2, 16'd8);
		repeat (100) @(posedge clk);
		nb = 0; nc = 0;
		repeat (1000) @(posedge clk);
		check("baud", nb inside {[49:51]}, 1);
		check("conn", nc inside {[24:26]}, 1);
		$display("test counters done");
		repeat (2) @(posedge clk);
		test_done;
	end
endmodule
